//--- shared/aio_defs.vh
// Constants for the analog I/O data, status and configuration block.
//
// Notes on behaviour
// - Channel words are 16-bit two's complement.
// - Result bits 11..0 sit at word 14..3.
// - Unused input word bits read as zero, except in the over-range code 7FFF.
// - Two output words, four input words.
// - One 16-bit word per input channel.
// - Outputs convert 15 or 16 bits by range.
// - Status length 0/8/16/24; zero disables.
// - 8 module, 16 plus inputs, 24 plus outputs.
// - Status byte one holds latest command error.
// - Function beats channel beats data error.
// - Errors never stop conversion or outputs.
// - Hold keeps last output on Run-to-Stop.
// - Default-low drives 4 mA/0 mA/0 V.
// - Four output ranges, five input ranges.
// - Alarms against limits; command may override.
// - 4-20 mA output clamps above 32000.
// - Over-range 7FFF, under-range 0000.
`ifndef AIO_DEFS_VH
`define AIO_DEFS_VH

// ----------------------------------------------------------------------------
// Register map (byte addresses on APB)
// ----------------------------------------------------------------------------
`define AIO_OFS_CTRL      12'h000
`define AIO_OFS_OUTRANGE  12'h004
`define AIO_OFS_INRANGE   12'h008
`define AIO_OFS_AQ0       12'h010
`define AIO_OFS_AQ1       12'h014
`define AIO_OFS_AI0       12'h020
`define AIO_OFS_STATUS    12'h030
`define AIO_OFS_ERRCMD    12'h034
`define AIO_OFS_LIM0      12'h040
`define AIO_OFS_AI_LAST   12'h02C
`define AIO_OFS_LIM_LAST  12'h04C

// ----------------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------------
`define AIO_CTRL_RUN      0
`define AIO_CTRL_DEFAULT_LOW_STOP 1
`define AIO_CTRL_SLEN_LO  2
`define AIO_CTRL_MODOK    4

// ----------------------------------------------------------------------------
// Ranges, status lengths, error codes
// ----------------------------------------------------------------------------
`define AIO_RNG_V10       3'd0
`define AIO_RNG_VBI       3'd1
`define AIO_RNG_I420      3'd2
`define AIO_RNG_I020      3'd3
`define AIO_RNG_I420E     3'd4
`define AIO_SLEN_0        2'd0
`define AIO_SLEN_8        2'd1
`define AIO_SLEN_16       2'd2
`define AIO_SLEN_24       2'd3
`define AIO_ERR_NONE      8'h00
`define AIO_ERR_FUNC      8'h01
`define AIO_ERR_CHAN      8'h02
`define AIO_ERR_DATA      8'h03
`define AIO_CLAMP_MAX     16'h7D00
`define AIO_FULL_SCALE    16'h7FFF
`define AIO_CTRL_RESET    32'h0000_0000
`define AIO_LIM_RESET     32'h7FF8_8000

`endif

//--- src/aio_core.v
// Analog I/O data formatting, status reporting and stop behaviour block.
//
// The register offsets and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "aio_defs.vh"

module aio_core #(
    parameter NUM_IN  = 4,                   // Input channel count.
    parameter NUM_OUT = 2                    // Output channel count.
) (
    input  wire        CLK,                  // System clock, 25 MHz.
    input  wire        RST,                  // Asynchronous reset, active high.
    input  wire        PSEL,                 // APB select.
    input  wire        PENABLE,              // APB access phase.
    input  wire        PWRITE,               // APB direction, high for write.
    input  wire [11:0] PADDR,                // APB byte address.
    input  wire [31:0] PWDATA,               // APB write data.
    output reg  [31:0] PRDATA,               // APB read data.
    output reg         PREADY,               // APB ready.
    output reg         PSLVERR,              // APB error on unmapped address.
    input  wire [47:0] ADC_DATA,             // Four 12-bit results, channel 0 low.
    input  wire [3:0]  ADC_VALID,            // Conversion done pulses per channel.
    input  wire [3:0]  ADC_OVER,             // Input above range per channel.
    input  wire [3:0]  ADC_UNDER,            // Input reversed or below range.
    input  wire        PWR_OK,               // Field power good, from a pin.
    input  wire        CMD_VALID,            // Host command request pulse.
    input  wire        CMD_FUNC_BAD,         // Command carries invalid function.
    input  wire        CMD_CHAN_BAD,         // Command names invalid channel.
    input  wire        CMD_DATA_BAD,         // Command carries invalid data.
    input  wire        CMD_LIM_WR,           // Command overrides alarm limits.
    input  wire [1:0]  CMD_CHAN,             // Channel addressed by command.
    input  wire [31:0] CMD_LIMITS,           // New high limit top, low limit bottom.
    output reg  [31:0] DAC_DATA,             // Two 16-bit codes to the converters.
    output reg  [23:0] STATUS_OUT            // Status bits as reported to host.
);

    // ------------------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------------------

    // Places a 12-bit result into an input word, honouring range limits.
    function [15:0] pack_in;
        input [11:0] res;
        input        over;
        input        under;
        begin
            if (over) begin
                pack_in = `AIO_FULL_SCALE;
            end else if (under) begin
                pack_in = 16'h0000;
            end else begin
                pack_in = {1'b0, res, 3'b000};
            end
        end
    endfunction

    // Output word after range handling; the 4-20 mA range is clamped.
    function [15:0] out_code;
        input [15:0] w;
        input [2:0]  rng;
        begin
            if (rng == `AIO_RNG_I420 && !w[15] && w > `AIO_CLAMP_MAX) begin
                out_code = `AIO_CLAMP_MAX;
            end else if (rng != `AIO_RNG_VBI && w[15]) begin
                out_code = 16'h0000;
            end else begin
                out_code = w;
            end
        end
    endfunction

    // ------------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------------
    reg  [31:0] ctrl_reg;                    // Run, stop mode, status length.
    reg  [5:0]  outrng_reg;                  // Three range bits per output.
    reg  [11:0] inrng_reg;                   // Three range bits per input.
    reg  [15:0] outw_reg [0:1];              // Output words from host.
    reg  [15:0] inw_reg [0:3];               // Formatted input words.
    reg  [31:0] lim_reg [0:3];               // Alarm limits, high over low.
    reg  [3:0]  alm_lo_reg;                  // Low alarm per input.
    reg  [3:0]  alm_hi_reg;                  // High alarm per input.
    reg  [7:0]  err_reg;                     // Latest command error code.
    reg         pwr_s1_reg;                  // Power sync stage one.
    reg         pwr_s2_reg;                  // Power sync stage two.
    reg         conv_seen_reg;               // Some conversion finished.
    reg  [7:0]  err_next;                    // Error code after this cycle.
    reg  [31:0] rd_next;                     // Read data for the access.
    reg         hit_next;                    // Address is mapped.
    reg  [23:0] stat_next;                   // Status after length gating.
    reg  [15:0] dac_next [0:1];              // Converter code per output.
    integer     i;                           // Loop index, clocked process.
    integer     k;                           // Loop index, output codes.

    wire        acc    = PSEL && PENABLE && !PREADY;   // One access per transfer.
    wire        wr     = acc && PWRITE;
    wire [1:0]  slen   = ctrl_reg[`AIO_CTRL_SLEN_LO+1:`AIO_CTRL_SLEN_LO];
    wire        run    = ctrl_reg[`AIO_CTRL_RUN];
    // Stop behaviour: high drives the low code, low holds the last code.
    wire        default_low_stop = ctrl_reg[`AIO_CTRL_DEFAULT_LOW_STOP];
    // Any command error this cycle; it must win over a software clear.
    wire        new_err = CMD_VALID && (CMD_FUNC_BAD || CMD_CHAN_BAD || CMD_DATA_BAD);

    // ------------------------------------------------------------------------
    // Command error priority
    // ------------------------------------------------------------------------

    // A new error overwrites the old; the highest priority one is kept.
    always @* begin
        err_next = err_reg;
        if (CMD_VALID) begin
            if (CMD_FUNC_BAD) begin
                err_next = `AIO_ERR_FUNC;
            end else if (CMD_CHAN_BAD) begin
                err_next = `AIO_ERR_CHAN;
            end else if (CMD_DATA_BAD) begin
                err_next = `AIO_ERR_DATA;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Status assembly
    // ------------------------------------------------------------------------

    // Byte 1 holds module, power and error; further bytes are length gated.
    always @* begin
        stat_next = 24'h00_0000;
        if (slen != `AIO_SLEN_0) begin
            stat_next[7:0] = {err_reg[3:0], 2'b00, pwr_s2_reg,
                              ctrl_reg[`AIO_CTRL_MODOK]};
        end
        if ((slen == `AIO_SLEN_16 || slen == `AIO_SLEN_24) && conv_seen_reg) begin
            stat_next[15:8] = {alm_hi_reg, alm_lo_reg};
        end
        if (slen == `AIO_SLEN_24) begin
            stat_next[23:16] = {6'b00_0000, run, default_low_stop};
        end
    end

    // ------------------------------------------------------------------------
    // Output codes with stop behaviour
    // ------------------------------------------------------------------------

    // Outputs follow the host while running; in stop, hold or default low.
    always @* begin
        for (k = 0; k < 2; k = k + 1) begin
            dac_next[k] = out_code(outw_reg[k], outrng_reg[3*k +: 3]);
            // Code zero is 4 mA, 0 mA or 0 V depending on the range.
            if (!run && default_low_stop) begin
                dac_next[k] = 16'h0000;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Read decode
    // ------------------------------------------------------------------------

    // Mapped registers answer; anything else reads zero with an error.
    always @* begin
        rd_next  = 32'h0000_0000;
        hit_next = 1'b1;
        case (PADDR)
            `AIO_OFS_CTRL:     rd_next = ctrl_reg;
            `AIO_OFS_OUTRANGE: rd_next = {26'd0, outrng_reg};
            `AIO_OFS_INRANGE:  rd_next = {20'd0, inrng_reg};
            `AIO_OFS_AQ0:      rd_next = {16'd0, outw_reg[0]};
            `AIO_OFS_AQ1:      rd_next = {16'd0, outw_reg[1]};
            `AIO_OFS_STATUS:   rd_next = {8'd0, stat_next};
            `AIO_OFS_ERRCMD:   rd_next = {24'd0, err_reg};
            default: begin
                if (PADDR >= `AIO_OFS_AI0 && PADDR <= `AIO_OFS_AI_LAST &&
                    PADDR[1:0] == 2'b00) begin
                    rd_next = {16'd0, inw_reg[PADDR[3:2]]};
                end else if (PADDR >= `AIO_OFS_LIM0 && PADDR <= `AIO_OFS_LIM_LAST &&
                             PADDR[1:0] == 2'b00) begin
                    rd_next = lim_reg[PADDR[3:2]];
                end else begin
                    hit_next = 1'b0;
                end
            end
        endcase
    end

    // ------------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------------

    // All state; writes land at the access edge, inputs and alarms update
    // on every conversion, never disturbed by command errors.
    always @(posedge CLK or posedge RST) begin
        if (RST) begin
            ctrl_reg      <= `AIO_CTRL_RESET;
            outrng_reg    <= 6'd0;
            inrng_reg     <= 12'd0;
            err_reg       <= `AIO_ERR_NONE;
            alm_lo_reg    <= 4'd0;
            alm_hi_reg    <= 4'd0;
            pwr_s1_reg    <= 1'b0;
            pwr_s2_reg    <= 1'b0;
            conv_seen_reg <= 1'b0;
            PRDATA        <= 32'h0000_0000;
            PREADY        <= 1'b0;
            PSLVERR       <= 1'b0;
            DAC_DATA      <= 32'h0000_0000;
            STATUS_OUT    <= 24'h00_0000;
            for (i = 0; i < 2; i = i + 1) begin
                outw_reg[i] <= 16'h0000;
            end
            for (i = 0; i < 4; i = i + 1) begin
                inw_reg[i] <= 16'h0000;
                lim_reg[i] <= `AIO_LIM_RESET;
            end
        end else begin
            pwr_s1_reg <= PWR_OK;
            pwr_s2_reg <= pwr_s1_reg;
            PREADY     <= acc;
            PSLVERR    <= acc && !hit_next;
            PRDATA     <= (acc && !PWRITE) ? rd_next : 32'h0000_0000;
            err_reg    <= err_next;
            STATUS_OUT <= stat_next;
            // Codes follow the host while running and load zero when stop drives low; in
            // hold mode the register is left alone, so the last code stays.
            if (run || default_low_stop) begin
                DAC_DATA <= {dac_next[1], dac_next[0]};
            end
            if (wr && hit_next) begin
                case (PADDR)
                    `AIO_OFS_CTRL:     ctrl_reg   <= PWDATA;
                    `AIO_OFS_OUTRANGE: outrng_reg <= PWDATA[5:0];
                    `AIO_OFS_INRANGE:  inrng_reg  <= PWDATA[11:0];
                    `AIO_OFS_AQ0:      outw_reg[0] <= PWDATA[15:0];
                    `AIO_OFS_AQ1:      outw_reg[1] <= PWDATA[15:0];
                    `AIO_OFS_ERRCMD: begin
                        // A new error in the same cycle wins over the clear.
                        if (!new_err) begin
                            err_reg <= `AIO_ERR_NONE;
                        end
                    end
                    default: begin
                        if (PADDR >= `AIO_OFS_LIM0) begin
                            lim_reg[PADDR[3:2]] <= PWDATA;
                        end
                    end
                endcase
            end
            // A valid limit command overrides the configured limits.
            if (CMD_VALID && CMD_LIM_WR && !CMD_FUNC_BAD && !CMD_CHAN_BAD &&
                !CMD_DATA_BAD) begin
                lim_reg[CMD_CHAN] <= CMD_LIMITS;
            end
            for (i = 0; i < 4; i = i + 1) begin
                if (ADC_VALID[i]) begin
                    conv_seen_reg <= 1'b1;
                    inw_reg[i] <= pack_in(ADC_DATA[12*i +: 12], ADC_OVER[i],
                                         ADC_UNDER[i]);
                    alm_lo_reg[i] <= $signed(pack_in(ADC_DATA[12*i +: 12], ADC_OVER[i],
                                     ADC_UNDER[i])) < $signed(lim_reg[i][15:0]);
                    alm_hi_reg[i] <= $signed(pack_in(ADC_DATA[12*i +: 12], ADC_OVER[i],
                                     ADC_UNDER[i])) > $signed(lim_reg[i][31:16]);
                end
            end
        end
    end

endmodule
`default_nettype wire

//--- test/aio_core_monitor.sv
// Port checker for the analog I/O core.
`timescale 1ns/1ps
`default_nettype none
`include "aio_defs.vh"
module aio_core_monitor (
    input wire logic        CLK,          // Clock.
    input wire logic        RST,          // Reset.
    input wire logic        PSEL,         // Select.
    input wire logic        PENABLE,      // Access.
    input wire logic        PWRITE,       // Write.
    input wire logic [11:0] PADDR,        // Address.
    input wire logic [31:0] PWDATA,       // Write data.
    input wire logic        PREADY,       // Ready.
    input wire logic        PSLVERR,      // Bus error.
    input wire logic        CMD_VALID,    // Request.
    input wire logic        CMD_FUNC_BAD, // Bad function.
    input wire logic        CMD_CHAN_BAD, // Bad channel.
    input wire logic        CMD_DATA_BAD, // Bad data.
    input wire logic [31:0] DAC_DATA,     // Output codes.
    input wire logic [23:0] STATUS_OUT    // Status.
);
    // ----------------------------------------
    // Control shadow
    // ----------------------------------------
    logic [4:0] ctl_q;   // Run, default-low, length, module-ok.
    wire        wr_any = PSEL && PENABLE && PWRITE;             // Write in access.
    wire        clr_err = wr_any && (PADDR == `AIO_OFS_ERRCMD); // Clear pending.
    wire        st_on = (ctl_q[3:2] != `AIO_SLEN_0);            // Status enabled.
    // Taken early in the access phase; the repetitions below absorb the skew.
    always @(posedge CLK or posedge RST) begin
        if (RST) begin
            ctl_q <= 5'h00;
        end else if (wr_any && (PADDR == `AIO_OFS_CTRL)) begin
            ctl_q <= PWDATA[4:0];
        end
    end
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);
    sequence s_setup;
        PSEL && !PENABLE;
    endsequence
    sequence s_access;
        PSEL && PENABLE && !PREADY;
    endsequence
    a_ready_one_wait: assert property (s_setup ##1 s_access |=> PREADY)
        else $error("ready not one cycle after access");
    a_ready_pulse: assert property (PREADY |=> !PREADY)
        else $error("ready longer than one cycle");
    a_slverr_ready: assert property (PSLVERR |-> PREADY && PSEL && PENABLE)
        else $error("bus error outside a transfer");
    a_reset_quiet: assert property ($fell(RST) |-> STATUS_OUT == 24'h00_0000 && DAC_DATA == 32'h0000_0000)
        else $error("outputs not quiet after reset");
    a_fixed_zero: assert property (STATUS_OUT[23:18] == 6'h00 && STATUS_OUT[7:6] == 2'h0 && STATUS_OUT[3:2] == 2'h0)
        else $error("unused status bits set");
    a_err_func_first: assert property (CMD_VALID && CMD_FUNC_BAD && st_on && !clr_err |-> ##[1:2] STATUS_OUT[7:4] == 4'h1)
        else $error("function error not first");
    a_err_data_last: assert property (CMD_VALID && !CMD_FUNC_BAD && !CMD_CHAN_BAD && CMD_DATA_BAD && st_on && !clr_err |-> ##[1:2] STATUS_OUT[7:4] == 4'h3)
        else $error("data error not reported");
    a_len_zero: assert property ((ctl_q[3:2] == `AIO_SLEN_0) [*3] |-> STATUS_OUT == 24'h00_0000)
        else $error("status shown at length zero");
    a_len_eight: assert property ((ctl_q[3:2] == `AIO_SLEN_8) [*3] |-> STATUS_OUT[23:8] == 16'h0000)
        else $error("status wider than eight bits");
    a_stop_low: assert property ((!ctl_q[0] && ctl_q[1]) [*4] |-> DAC_DATA == 32'h0000_0000)
        else $error("stopped outputs not low");
    a_stop_hold: assert property ((!ctl_q[0] && !ctl_q[1]) [*3] |=> $stable(DAC_DATA))
        else $error("stopped outputs moved");
endmodule
bind aio_core aio_core_monitor mon (.CLK(CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .CMD_VALID(CMD_VALID), .CMD_FUNC_BAD(CMD_FUNC_BAD), .CMD_CHAN_BAD(CMD_CHAN_BAD),
    .CMD_DATA_BAD(CMD_DATA_BAD), .DAC_DATA(DAC_DATA), .STATUS_OUT(STATUS_OUT));
`default_nettype wire

//--- test/host_cmd_model.sv
// Host command request model for the analog I/O core.
`timescale 1ns/1ps
`default_nettype none
module host_cmd_model (
    input  wire logic        clk,      // Clock.
    output var  logic        valid,    // Request pulse.
    output var  logic        func_bad, // Bad function.
    output var  logic        chan_bad, // Bad channel.
    output var  logic        data_bad, // Bad data.
    output var  logic        lim_wr,   // Limit override.
    output var  logic [1:0]  chan,     // Target channel.
    output var  logic [31:0] limits    // High word, low word.
);
    // Quiet start before the first request.
    initial begin
        {valid, func_bad, chan_bad, data_bad, lim_wr, chan, limits} = '0;
    end
    // One-cycle request; qualifiers are scrambled after it, so the core must gate them.
    task send(input logic [2:0] bad, input logic lw, input logic [1:0] ch,
              input logic [31:0] lims);
        @(posedge clk);
        valid <= 1'b1;
        {func_bad, chan_bad} <= bad[2:1];
        data_bad <= bad[0] | (lw & ($signed(lims[15:0]) >= $signed(lims[31:16])));
        lim_wr <= lw;
        chan <= ch;
        limits <= lims;
        @(posedge clk);
        valid <= 1'b0;
        {func_bad, chan_bad, data_bad, lim_wr, chan, limits} <= ~{bad, lw, ch, lims};
    endtask
endmodule
`default_nettype wire

//--- test/analog_io_data_status_test.sv
// Self-checking bench for the analog I/O core.
`timescale 1ns/1ps
`default_nettype none
`include "aio_defs.vh"
module analog_io_data_status_test;
    // ----------------------------------------
    // Signals and tables
    // ----------------------------------------
    logic             CLK, RST, PSEL, PENABLE, PWRITE, PWR_OK, err_q; // Bus, power, bus error.
    logic [11:0]      PADDR;                           // Address.
    logic [31:0]      PWDATA, rd_q;                    // Write data, last read.
    logic [47:0]      ADC_DATA;                        // Results.
    logic [3:0]       ADC_VALID, ADC_OVER, ADC_UNDER;  // Converter flags.
    wire logic [31:0] PRDATA, DAC_DATA, CMD_LIMITS;    // Read data, codes, limits.
    wire logic        PREADY, PSLVERR, CMD_VALID, CMD_LIM_WR; // Handshakes.
    wire logic        CMD_FUNC_BAD, CMD_CHAN_BAD, CMD_DATA_BAD; // Command flags.
    wire logic [1:0]  CMD_CHAN;                        // Command channel.
    wire logic [23:0] STATUS_OUT;                      // Status.
    int               error_cnt = 0;                   // Mismatches.
    int               checks_done = 0;                 // Comparisons.
    typedef struct packed {logic [1:0] ch; logic [11:0] res; logic ov; logic un; logic [15:0] w;} row_t;
    row_t rows [5] = '{'{2'd0, 12'hFFE, 1'b0, 1'b0, 16'h7FF0}, '{2'd1, 12'h001, 1'b0, 1'b0, 16'h0008},
        '{2'd2, 12'hABC, 1'b1, 1'b0, 16'h7FFF}, '{2'd3, 12'h555, 1'b0, 1'b1, 16'h0000},
        '{2'd3, 12'h800, 1'b0, 1'b0, 16'h4000}};
    logic [2:0]       bad_tab [5] = '{3'b111, 3'b011, 3'b001, 3'b100, 3'b010}; // Flags sent.
    logic [3:0]       err_tab [5] = '{4'h1, 4'h2, 4'h3, 4'h1, 4'h2};           // Codes due.
    aio_core dut (.CLK(CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
        .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
        .ADC_DATA(ADC_DATA), .ADC_VALID(ADC_VALID), .ADC_OVER(ADC_OVER), .ADC_UNDER(ADC_UNDER),
        .PWR_OK(PWR_OK), .CMD_VALID(CMD_VALID), .CMD_FUNC_BAD(CMD_FUNC_BAD),
        .CMD_CHAN_BAD(CMD_CHAN_BAD), .CMD_DATA_BAD(CMD_DATA_BAD), .CMD_LIM_WR(CMD_LIM_WR),
        .CMD_CHAN(CMD_CHAN), .CMD_LIMITS(CMD_LIMITS), .DAC_DATA(DAC_DATA), .STATUS_OUT(STATUS_OUT));
    host_cmd_model host (.clk(CLK), .valid(CMD_VALID), .func_bad(CMD_FUNC_BAD),
        .chan_bad(CMD_CHAN_BAD), .data_bad(CMD_DATA_BAD), .lim_wr(CMD_LIM_WR),
        .chan(CMD_CHAN), .limits(CMD_LIMITS));
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // Bus cycle; waits on ready with no assumed latency, the watchdog ends a hang.
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge CLK);
        PSEL <= 1'b1;
        PWRITE <= wr;
        PADDR <= a;
        PWDATA <= d;
        @(posedge CLK);
        PENABLE <= 1'b1;
        do @(posedge CLK); while (PREADY !== 1'b1);
        rd_q = PRDATA;
        err_q = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask
    task rdc(input logic [11:0] a, input logic [31:0] e, input string nm);
        apb(1'b0, a, 32'h0000_0000);
        chk(nm, rd_q, e);
    endtask
    task conv(input logic [1:0] ch, input logic [11:0] res, input logic ov, input logic un);
        @(posedge CLK);
        ADC_DATA[ch*12 +: 12] <= res;
        ADC_OVER[ch] <= ov;
        ADC_UNDER[ch] <= un;
        ADC_VALID[ch] <= 1'b1;
        @(posedge CLK);
        ADC_VALID <= 4'h0;
    endtask
    task dac_chk(input logic [31:0] e);
        repeat (4) @(posedge CLK);
        chk("output codes", DAC_DATA, e);
    endtask
    task wrap_up;
        if (error_cnt == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // ----------------------------------------
    // Clock, watchdog and sequence
    // ----------------------------------------
    initial begin
        CLK = 1'b0;
        forever #20 CLK = ~CLK;
    end
    // The run needs under three hundred cycles; twenty thousand means a hang.
    initial begin
        #800000;
        error_cnt++;
        wrap_up;
    end
    initial begin
        {PSEL, PENABLE, PWRITE, PADDR, PWDATA, ADC_DATA, ADC_VALID, ADC_OVER, ADC_UNDER} = '0;
        PWR_OK = 1'b1;
        RST = 1'b1;
        repeat (12) @(posedge CLK);
        RST <= 1'b0;
        rdc(`AIO_OFS_CTRL, `AIO_CTRL_RESET, "control");
        rdc(`AIO_OFS_ERRCMD, 32'h0000_0000, "error code");
        rdc(`AIO_OFS_LIM0, 32'h7FF8_8000, "limits");
        chk("status port", STATUS_OUT, 32'h0000_0000);
        apb(1'b1, `AIO_OFS_CTRL, 32'h0000_001D);
        for (int i = 0; i < 5; i++) begin
            conv(rows[i].ch, rows[i].res, rows[i].ov, rows[i].un);
            rdc(`AIO_OFS_AI0 + {8'h00, rows[i].ch, 2'b00}, {16'h0000, rows[i].w}, "input word");
        end
        for (int s = 0; s < 4; s++) begin
            apb(1'b1, `AIO_OFS_CTRL, {27'h000_0000, 1'b1, s[1:0], 2'b01});
            repeat (4) @(posedge CLK);
            chk("status", STATUS_OUT, (s == 0) ? 24'h00_0000 : 24'h02_4003 & (24'hFF_FFFF >> (8 * (3 - s))));
        end
        for (int i = 0; i < 5; i++) begin
            host.send(bad_tab[i], 1'b0, 2'd0, 32'h0000_0000);
            repeat (3) @(posedge CLK);
            chk("error nibble", STATUS_OUT[7:4], err_tab[i]);
            rdc(`AIO_OFS_ERRCMD, {28'h000_0000, err_tab[i]}, "error code");
        end
        PWR_OK <= 1'b0;
        repeat (4) @(posedge CLK);
        chk("power bit", STATUS_OUT[1], 1'b0);
        PWR_OK <= 1'b1;
        host.send(3'b000, 1'b1, 2'd3, 32'h1000_0000);
        rdc(`AIO_OFS_LIM0 + 12'h00C, 32'h1000_0000, "override");
        host.send(3'b000, 1'b1, 2'd3, 32'h0000_1000);
        rdc(`AIO_OFS_LIM0 + 12'h00C, 32'h1000_0000, "bad override");
        rdc(`AIO_OFS_ERRCMD, 32'h0000_0003, "limit error");
        conv(2'd3, 12'h800, 1'b0, 1'b0);
        repeat (3) @(posedge CLK);
        chk("alarm byte", STATUS_OUT[15:8], 32'h0000_00C0);
        apb(1'b1, `AIO_OFS_OUTRANGE, 32'h0000_0002);
        apb(1'b1, `AIO_OFS_AQ0, 32'h0000_7FFF);
        apb(1'b1, `AIO_OFS_AQ1, 32'h0000_7FFF);
        dac_chk(32'h7FFF_7D00);
        apb(1'b1, `AIO_OFS_AQ1, 32'h0000_8000);
        dac_chk(32'h0000_7D00);
        apb(1'b1, `AIO_OFS_OUTRANGE, 32'h0000_000A);
        dac_chk(32'h8000_7D00);
        apb(1'b1, `AIO_OFS_CTRL, 32'h0000_001C);
        apb(1'b1, `AIO_OFS_AQ0, 32'h0000_1234);
        dac_chk(32'h8000_7D00);
        apb(1'b1, `AIO_OFS_CTRL, 32'h0000_001E);
        dac_chk(32'h0000_0000);
        apb(1'b1, `AIO_OFS_CTRL, 32'h0000_001D);
        dac_chk(32'h8000_1234);
        apb(1'b1, `AIO_OFS_OUTRANGE, 32'h0000_000B);
        apb(1'b1, `AIO_OFS_AQ0, 32'h0000_7FFF);
        dac_chk(32'h8000_7FFF);
        rdc(12'h0FC, 32'h0000_0000, "unmapped read");
        chk("bus error", {31'h0000_0000, err_q}, 32'h0000_0001);
        apb(1'b1, `AIO_OFS_AI0, 32'h0000_FFFF);
        rdc(`AIO_OFS_AI0, 32'h0000_7FF0, "read-only word");
        apb(1'b1, `AIO_OFS_ERRCMD, 32'h0000_0001);
        rdc(`AIO_OFS_ERRCMD, 32'h0000_0000, "error clear");
        @(posedge CLK);
        RST <= 1'b1;
        repeat (2) @(posedge CLK);
        RST <= 1'b0;
        rdc(`AIO_OFS_LIM0 + 12'h00C, 32'h7FF8_8000, "limits after reset");
        chk("status after reset", STATUS_OUT, 32'h0000_0000);
        chk("codes after reset", DAC_DATA, 32'h0000_0000);
        wrap_up;
    end
endmodule
`default_nettype wire
